/* File: hdl/rss_sequencer.v */
// ten-step power rail sequencer with its four byte configuration registers
// assumes byte register access from same-clock logic (serial slave decoded
// elsewhere) and that the unlock level comes from the password logic
//
// What this block does
// - low gap bits pick 2/5 ms, steps 1-8
// - high register bit0 picks gap after step nine
// - high bit7 stretches gaps tenfold on power-down
// - power-up always uses unscaled gaps
// - codes 3h..Ah enable rail at that step
// - other codes leave the rail untouched
// - converter one field bits 3-0, reset 6h
// - converter two field bits 7-4, reset 5h
// - converter four 7-4 reset 4h, three 3-0 5h
// - high register bits 6-1 read zero, ignore writes
`timescale 1ns/1ps
`include "rss_regs.vh"
module rss_sequencer #(
   parameter TICK_CYCLES = `RSS_TICK_CYCLES  // clocks per millisecond
) (
   input  wire       clk,
   input  wire       reset,
   input  wire [7:0] regAddr,        // byte register subaddress
   input  wire [7:0] regWrData,      // write data
   input  wire       regWrite,       // one-cycle write strobe
   input  wire       regRead,        // one-cycle read strobe
   input  wire       unlocked,       // password unlock held by caller
   input  wire       powerUpReq,     // one-cycle start of power-up
   input  wire       powerDownReq,   // one-cycle start of power-down
   output reg  [7:0] regRdData,      // read data, valid cycle after regRead
   output reg  [3:0] railEnable,     // converter four..one enables
   output reg  [3:0] currentStep,    // step now being served, 0 when idle
   output reg        seqBusy,        // sequence in progress
   output reg        railsUp         // last finished sequence was power-up
);

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   reg [7:0] gapLow;                 // gap_after_step_one..eight
   reg       gapAfterStepNine;       // gap_after_step_nine
   reg       powerdownGapMultiplier; // tenfold stretch on power-down
   reg [3:0] converterOneStep;
   reg [3:0] converterTwoStep;
   reg [3:0] converterThreeStep;
   reg [3:0] converterFourStep;

   // sequencer state
   localparam [2:0] S_IDLE    = 3'h0;
   localparam [2:0] S_UP_STEP = 3'h1;
   localparam [2:0] S_UP_WAIT = 3'h2;
   localparam [2:0] S_DN_STEP = 3'h3;
   localparam [2:0] S_DN_WAIT = 3'h4;

   reg  [2:0] state;
   reg  [5:0] waitMs;                // whole milliseconds left in a gap
   reg        tickRestart;           // realign timebase when a gap starts
   wire       msTick;                // millisecond enable pulse
   wire [3:0] stepMatch;             // rails assigned to currentStep
   wire [9:0] gapBits;               // gap select per step 1..9, bit n-1

   // reset images, so each field takes its own slice and nothing is cut silently
   wire [7:0] rstGapHigh   = `RSS_RST_GAP_HIGH;
   wire [7:0] rstOneTwo    = `RSS_RST_CONV_ONE_TWO;
   wire [7:0] rstThreeFour = `RSS_RST_CONV_THREE_FOUR;

   ////////////////////////////////////////////////////////////////////
   // helpers

   // true when a step field names this step; out-of-range codes never do
   function railAtStep;
      input [3:0] field;
      input [3:0] step;
      begin
         railAtStep = (field >= `RSS_STEP_FIRST_CTRL) &&
                      (field <= `RSS_STEP_LAST_CTRL) &&
                      (field == step);
      end
   endfunction

   // gap length in ms; the stretch applies only when powering down
   function [5:0] gapMs;
      input longSel;
      input stretch;
      reg [5:0] base;
      begin
         base = longSel ? `RSS_GAP_LONG_MS : `RSS_GAP_SHORT_MS;
         if (stretch)
            gapMs = longSel ? (`RSS_GAP_LONG_MS * `RSS_PD_FACTOR)
                            : (`RSS_GAP_SHORT_MS * `RSS_PD_FACTOR);
         else
            gapMs = base;
      end
   endfunction

   assign gapBits = {1'b0, gapAfterStepNine, gapLow};
   assign stepMatch = {railAtStep(converterFourStep, currentStep),
                       railAtStep(converterThreeStep, currentStep),
                       railAtStep(converterTwoStep, currentStep),
                       railAtStep(converterOneStep, currentStep)};

   ////////////////////////////////////////////////////////////////////
   // millisecond timebase
   rss_ms_tick #(
      .CYCLES (TICK_CYCLES),
      .CW     (14)
   ) u_tick (
      .clk     (clk),
      .reset   (reset),
      .restart (tickRestart),
      .tick    (msTick)
   );

   ////////////////////////////////////////////////////////////////////
   // register writes; locked writes are dropped silently
   always @(posedge clk) begin
      if (reset) begin
         gapLow                 <= `RSS_RST_GAP_LOW;
         gapAfterStepNine       <= rstGapHigh[`RSS_POS_GAP_NINE];
         powerdownGapMultiplier <= rstGapHigh[`RSS_POS_PD_MULT];
         converterOneStep       <= rstOneTwo[`RSS_POS_CONV_ONE +: 4];
         converterTwoStep       <= rstOneTwo[`RSS_POS_CONV_TWO +: 4];
         converterThreeStep     <= rstThreeFour[`RSS_POS_CONV_THREE +: 4];
         converterFourStep      <= rstThreeFour[`RSS_POS_CONV_FOUR +: 4];
      end else if (regWrite && unlocked) begin
         case (regAddr)
            `RSS_OFS_GAP_LOW: begin
               gapLow <= regWrData;
            end
            `RSS_OFS_GAP_HIGH: begin
               // reserved bits 6-1 are not stored
               gapAfterStepNine       <= regWrData[`RSS_POS_GAP_NINE];
               powerdownGapMultiplier <= regWrData[`RSS_POS_PD_MULT];
            end
            `RSS_OFS_CONV_ONE_TWO: begin
               converterOneStep <= regWrData[`RSS_POS_CONV_ONE +: 4];
               converterTwoStep <= regWrData[`RSS_POS_CONV_TWO +: 4];
            end
            `RSS_OFS_CONV_THREE_FOUR: begin
               converterThreeStep <= regWrData[`RSS_POS_CONV_THREE +: 4];
               converterFourStep  <= regWrData[`RSS_POS_CONV_FOUR +: 4];
            end
            default: begin
               // unmapped subaddress: nothing stored
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register reads, registered; unmapped reads return zero
   always @(posedge clk) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `RSS_OFS_GAP_LOW:
               regRdData <= gapLow;
            `RSS_OFS_GAP_HIGH:
               regRdData <= {powerdownGapMultiplier, 6'h00, gapAfterStepNine};
            `RSS_OFS_CONV_ONE_TWO:
               regRdData <= {converterTwoStep, converterOneStep};
            `RSS_OFS_CONV_THREE_FOUR:
               regRdData <= {converterFourStep, converterThreeStep};
            default:
               regRdData <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // step sequencer; requests are ignored while a sequence runs, so a
   // power-down cannot cut a power-up short (finish, then ask again)
   always @(posedge clk) begin
      if (reset) begin
         state       <= S_IDLE;
         currentStep <= 4'h0;
         waitMs      <= 6'h00;
         tickRestart <= 1'b0;
         railEnable  <= 4'h0;
         seqBusy     <= 1'b0;
         railsUp     <= 1'b0;
      end else begin
         tickRestart <= 1'b0;
         case (state)
            S_IDLE: begin
               if (powerUpReq) begin
                  currentStep <= `RSS_STEP_FIRST;
                  seqBusy     <= 1'b1;
                  state       <= S_UP_STEP;
               end else if (powerDownReq) begin
                  currentStep <= `RSS_STEP_LAST;
                  seqBusy     <= 1'b1;
                  state       <= S_DN_STEP;
               end
            end
            S_UP_STEP: begin
               // rails named by this step come on; others keep their level
               railEnable <= railEnable | stepMatch;
               if (currentStep == `RSS_STEP_LAST) begin
                  seqBusy <= 1'b0;
                  railsUp <= 1'b1;
                  currentStep <= 4'h0;
                  state   <= S_IDLE;
               end else begin
                  // power-up never stretches, whatever the multiplier holds
                  waitMs      <= gapMs(gapBits[currentStep - 4'h1], 1'b0);
                  tickRestart <= 1'b1;
                  state       <= S_UP_WAIT;
               end
            end
            S_UP_WAIT: begin
               // a pulse from before the realign would cut the gap short
               if (msTick && !tickRestart) begin
                  if (waitMs == 6'h01) begin
                     currentStep <= currentStep + 4'h1;
                     state       <= S_UP_STEP;
                  end
                  waitMs <= waitMs - 6'h01;
               end
            end
            S_DN_STEP: begin
               // reverse order: rails of this step go off
               railEnable <= railEnable & ~stepMatch;
               if (currentStep == `RSS_STEP_FIRST) begin
                  seqBusy <= 1'b0;
                  railsUp <= 1'b0;
                  currentStep <= 4'h0;
                  state   <= S_IDLE;
               end else begin
                  waitMs      <= gapMs(gapBits[currentStep - 4'h2],
                                       powerdownGapMultiplier);
                  tickRestart <= 1'b1;
                  state       <= S_DN_WAIT;
               end
            end
            S_DN_WAIT: begin
               // same guard against a pulse left from the old period
               if (msTick && !tickRestart) begin
                  if (waitMs == 6'h01) begin
                     currentStep <= currentStep - 4'h1;
                     state       <= S_DN_STEP;
                  end
                  waitMs <= waitMs - 6'h01;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: inc/rss_regs.vh */
// register map, field positions, reset values and timing figures of the
// rail strobe sequencer; definitions only, included by the sequencer files
`ifndef RSS_REGS_VH
`define RSS_REGS_VH

// byte register offsets (subaddresses)
`define RSS_OFS_GAP_LOW        8'h20
`define RSS_OFS_GAP_HIGH       8'h21
`define RSS_OFS_CONV_ONE_TWO   8'h22
`define RSS_OFS_CONV_THREE_FOUR 8'h23

// reset values
`define RSS_RST_GAP_LOW        8'h00
`define RSS_RST_GAP_HIGH       8'h00
`define RSS_RST_CONV_ONE_TWO   8'h56
`define RSS_RST_CONV_THREE_FOUR 8'h45

// field positions in the high gap register
`define RSS_POS_GAP_NINE       0
`define RSS_POS_PD_MULT        7
// writable bits of the high gap register, bits 6-1 are reserved
`define RSS_MASK_GAP_HIGH      8'h81

// field positions (low bit) of the step fields
`define RSS_POS_CONV_ONE       0
`define RSS_POS_CONV_TWO       4
`define RSS_POS_CONV_THREE     0
`define RSS_POS_CONV_FOUR      4

// step codes that put a rail under sequencer control, then the first and last step of a sequence
`define RSS_STEP_FIRST_CTRL    4'h3
`define RSS_STEP_LAST_CTRL     4'hA
`define RSS_STEP_FIRST         4'h1
`define RSS_STEP_LAST          4'hA

// timing: gap choices in ms, power-down factor, timebase
`define RSS_GAP_SHORT_MS       6'h02
`define RSS_GAP_LONG_MS        6'h05
`define RSS_PD_FACTOR          6'h0A
`define RSS_CLK_PERIOD_NS      100
`define RSS_TICK_NS            1000000
`define RSS_TICK_CYCLES        (`RSS_TICK_NS / `RSS_CLK_PERIOD_NS)

`endif

/* File: hdl/rss_ms_tick.v */
// millisecond timebase: one-cycle enable pulse every CYCLES clocks
// assumes a single clock; restart realigns the period to the caller
`timescale 1ns/1ps
module rss_ms_tick #(
   parameter CYCLES = 10000,   // clocks per tick
   parameter CW     = 14       // counter width, must hold CYCLES-1
) (
   input  wire clk,
   input  wire reset,
   input  wire restart,        // start a fresh full period
   output reg  tick            // one-cycle pulse
);

   reg [CW-1:0] count;         // clocks left in this period

   ////////////////////////////////////////////////////////////////////
   // down counter; restart lets a wait last exactly whole periods
   always @(posedge clk) begin
      if (reset || restart) begin
         count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
         tick  <= 1'b0;
      end else if (count == {CW{1'b0}}) begin
         count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
         tick  <= 1'b1;
      end else begin
         count <= count - {{(CW-1){1'b0}}, 1'b1};
         tick  <= 1'b0;
      end
   end

endmodule

/* File: bench/rss_sequencer_properties.sv */
// port checker for the rail strobe sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module rss_sequencer_properties #(
   parameter TICK_CYCLES = 10
) (
   input wire       clk,
   input wire       reset,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire       regWrite,
   input wire       regRead,
   input wire       unlocked,
   input wire       powerUpReq,
   input wire       powerDownReq,
   input wire [7:0] regRdData,
   input wire [3:0] railEnable,
   input wire [3:0] currentStep,
   input wire       seqBusy,
   input wire       railsUp
);
   localparam int GMIN = 2 * TICK_CYCLES;      // shortest gap
   localparam int GMAX = 50 * TICK_CYCLES + 3; // stretched long gap plus step cycles
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0]  prevStep; // step seen last cycle
   logic [15:0] dwell;    // cycles spent in the shown step
   // dwell restarts on every step change
   always_ff @(posedge clk) begin
      prevStep <= currentStep;
      dwell    <= (reset || currentStep != prevStep) ? 16'h0001 : dwell + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_reserved_read_zero: assert property (
      regRead && regAddr == 8'h21 |=> regRdData[6:1] == 6'h00) else $error("reserved bits set");
   a_unmapped_read: assert property (
      regRead && (regAddr < 8'h20 || regAddr > 8'h23) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_start_up: assert property (
      powerUpReq && !seqBusy |=> seqBusy && currentStep == 4'h1) else $error("bad power-up start");
   a_start_down: assert property (
      powerDownReq && !powerUpReq && !seqBusy |=> seqBusy && currentStep == 4'hA)
      else $error("bad power-down start");
   a_step_adjacent: assert property (
      seqBusy && $past(seqBusy) && currentStep != $past(currentStep) |->
      currentStep == $past(currentStep) + 4'h1 || currentStep == $past(currentStep) - 4'h1)
      else $error("step skipped");
   a_rail_after_step: assert property (
      railEnable != $past(railEnable) |-> $past(currentStep) != $past(currentStep, 2))
      else $error("rail moved off a step entry");
   a_idle_rails_hold: assert property (
      !seqBusy && !$past(seqBusy) |-> $stable(railEnable)) else $error("rail moved while idle");
   a_gap_bounds: assert property (
      seqBusy && $past(seqBusy) && currentStep != prevStep |-> dwell >= GMIN && dwell <= GMAX)
      else $error("gap out of range");
   a_up_done: assert property (
      $fell(seqBusy) && $past(currentStep) == 4'hA |-> ##[0:1] railsUp) else $error("no railsUp");
   c_up_done: cover property ($fell(seqBusy) && railsUp);
   c_locked_write: cover property (regWrite && !unlocked);
   c_down_start: cover property (powerDownReq && !seqBusy);
endmodule
bind rss_sequencer rss_sequencer_properties #(.TICK_CYCLES(TICK_CYCLES)) rss_props_inst (
   .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .unlocked(unlocked), .powerUpReq(powerUpReq),
   .powerDownReq(powerDownReq), .regRdData(regRdData), .railEnable(railEnable),
   .currentStep(currentStep), .seqBusy(seqBusy), .railsUp(railsUp));

/* File: bench/tb.sv */
// self-checking bench for the rail strobe sequencer
// assumes the byte port protocol and a shortened millisecond of T clocks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
   localparam int T = 10;  // short timebase keeps the run brief
   logic       clk = 0, reset = 1, regWrite = 0, regRead = 0, unlocked = 0;
   logic       powerUpReq = 0, powerDownReq = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
   wire  [7:0] regRdData;
   wire  [3:0] railEnable, currentStep;
   wire        seqBusy, railsUp;
   int         miscompares = 0, comparisons = 0, d0, d1, d2, e0, e1, e2;
   logic [3:0] edgeStep [4]; // step at which each rail last moved
   always #50 clk = ~clk;
   rss_sequencer #(.TICK_CYCLES(T)) rss_sequencer_inst (.clk(clk), .reset(reset),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .unlocked(unlocked), .powerUpReq(powerUpReq), .powerDownReq(powerDownReq),
      .regRdData(regRdData), .railEnable(railEnable), .currentStep(currentStep),
      .seqBusy(seqBusy), .railsUp(railsUp));
   ////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one-cycle write strobe
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // read data lands at the edge after the strobe
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      `CHK("regRdData", e, regRdData)
   endtask
   // one full sequence; dur counts busy cycles, rail moves logged by step
   task run(input bit up, output int dur);
      int n, tail;
      logic [3:0] prev, pStep;
      @(posedge clk);
      powerUpReq <= up;
      powerDownReq <= !up;
      @(posedge clk);
      powerUpReq <= 1'b0;
      powerDownReq <= 1'b0;
      dur = 0;
      tail = 0;
      prev = railEnable;
      pStep = currentStep;
      for (int b = 0; b < 4; b++) edgeStep[b] = 4'h0;
      for (n = 0; n < 9000 && tail < 3; n++) begin
         @(negedge clk);
         if (seqBusy === 1'b1) dur++;
         else if (dur > 0) tail++;
         // a rail moves one cycle after its step is entered
         for (int b = 0; b < 4; b++) if (railEnable[b] !== prev[b]) edgeStep[b] = pStep;
         prev = railEnable;
         pStep = currentStep;
      end
      if (n == 9000) begin
         miscompares++;
         results();
      end
   endtask
   // f holds expected move steps, converter four in the top nibble
   task rails(input [15:0] f, input [3:0] en);
      for (int b = 0; b < 4; b++) `CHK("rail step", f[4*b+:4], edgeStep[b])
      `CHK("railEnable", en, railEnable)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [3:0] c;
      bit ctl;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(8'h20, 8'h00);
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h56);
      rd(8'h23, 8'h45);
      rd(8'h24, 8'h00);
      wr(8'h22, 8'hA3);
      rd(8'h22, 8'h56);
      @(posedge clk);
      unlocked <= 1'b1;
      wr(8'h21, 8'hFF);
      rd(8'h21, 8'h81);
      wr(8'h21, 8'h00);
      $display("test registers done");
      run(1, d0);
      rails(16'h4556, 4'hF);
      `CHK("railsUp", 1'b1, railsUp)
      run(0, e0);
      rails(16'h4556, 4'h0);
      `CHK("railsUp", 1'b0, railsUp)
      wr(8'h20, 8'h01);
      run(1, d1);
      run(0, e1);
      `CHK("up gap one", 3 * T, d1 - d0)
      `CHK("down gap one", 3 * T, e1 - e0)
      wr(8'h21, 8'h81);
      run(1, d2);
      run(0, e2);
      `CHK("up gap nine", 3 * T, d2 - d1)
      `CHK("down stretch", 3 * T + 9 * 24 * T, e2 - e1)
      $display("test timing done");
      wr(8'h21, 8'h00);
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         ctl = (i >= 3 && i <= 10);
         wr(8'h22, {c, c});
         wr(8'h23, {c, c});
         run(1, d0);
         rails(ctl ? {4{c}} : 16'h0000, ctl ? 4'hF : 4'h0);
         run(0, e0);
         rails(ctl ? {4{c}} : 16'h0000, 4'h0);
      end
      $display("test codes done");
      // reset in mid-sequence: outputs clear, registers return to defaults
      wr(8'h22, 8'h33);
      @(posedge clk);
      powerUpReq <= 1'b1;
      @(posedge clk);
      powerUpReq <= 1'b0;
      repeat (200) @(posedge clk);
      `CHK("rails on before reset", 4'h3, railEnable)
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK("seqBusy", 1'b0, seqBusy)
      `CHK("railEnable", 4'h0, railEnable)
      `CHK("currentStep", 4'h0, currentStep)
      `CHK("railsUp", 1'b0, railsUp)
      rd(8'h20, 8'h00);
      rd(8'h22, 8'h56);
      rd(8'h23, 8'h45);
      $display("test reset done");
      results();
   end
endmodule
